// ===== uwc_pkg.sv
// Constants for the serial wire control block: offsets, fields, resets.
// Assumes an 8-bit register port with byte-wide data.
package uwc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'hB8;
   localparam logic [7:0] STAT_OFS = 8'hB9;
   localparam logic [7:0] DATA_OFS = 8'hBA;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [3:0] CNT_MAX = 4'hF;

   // ----------------------------------------
   // Control field positions
   // ----------------------------------------
   localparam int C_SIE = 7;
   localparam int C_OIE = 6;
   localparam int C_WM_HI = 5;
   localparam int C_WM_LO = 4;
   localparam int C_CS_HI = 3;
   localparam int C_CS_LO = 2;
   localparam int C_CLK = 1;
   localparam int C_TC = 0;

   // ----------------------------------------
   // Status field positions
   // ----------------------------------------
   localparam int S_SIF = 7;
   localparam int S_OIF = 6;
   localparam int S_PF = 5;
   localparam int S_DC = 4;
   localparam int S_CNT_HI = 3;

   // ----------------------------------------
   // Modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      WM_OFF = 2'h0,
      WM_THREE = 2'h1,
      WM_TWO = 2'h2,
      WM_TWO_HOLD = 2'h3
   } uwc_wm_t;

   typedef enum logic [1:0] {
      CS_SOFT = 2'h0,
      CS_TIMER = 2'h1,
      CS_EXT_POS = 2'h2,
      CS_EXT_NEG = 2'h3
   } uwc_cs_t;
endpackage

// ===== uwc_top.sv
// Serial wire control: counter, flags, wire-mode pin steering.
// Assumes port bits come from port logic on the same clock and the
// serial pins are asynchronous; global interrupt enable lives outside.
//
// Operation
// - Stop sets stop flag, write-one clears
// - Collision bit: shift MSB differs from pin
// - Counter readable and writable in status
// - Counter ticks from edge, timer or strobe
// - Toggle strobe plus clock strobe clocks counter in external select
// - External clock counts even with outputs off
// - Control layout, strobes write-only, reset zero
// - Start enable gates start request
// - Overflow enable gates overflow request
// - Mode affects outputs and start/stop flags, inputs always live
// - Mode zero: ordinary port pins
// - Three-wire: data output overrides port bit
// - Two-wire data open-drain, low on zero
// - Two-wire clock low on port zero or hold
// - Start hold keeps clock low until cleared
// - Two-wire disables both pull-ups
// - Mode three also holds on overflow
// - Start flag: start in two-wire, else tick
// - Overflow flag on wrap, write-one clears
// - Source zero: clock strobe clocks both
`timescale 1ns/10ps
module uwc_top (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // Port register bits from the port logic
   input wire logic port_do_in,
   input wire logic ddr_do_in,
   input wire logic port_sda_in,
   input wire logic ddr_sda_in,
   input wire logic port_scl_in,
   input wire logic ddr_scl_in,
   input wire logic timer_match_in,
   // Serial pins, asynchronous inputs
   input wire logic data_input_pin_in,
   input wire logic serial_clock_pin_in,
   // Data output pin
   output logic do_out,
   output logic do_oe_out,
   output logic do_pullup_out,
   // Data pin (SDA) drive
   output logic sda_out,
   output logic sda_oe_out,
   output logic sda_pullup_out,
   // Clock pin (SCL) drive
   output logic scl_out,
   output logic scl_oe_out,
   output logic scl_pullup_out,
   output logic scl_toggle_out,
   // Interrupt requests before the global enable
   output logic start_irq_out,
   output logic ovf_irq_out
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_a_q;
   logic rst_n;

   // Two flops so the release is clean to the clock
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_a_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_n <= rst_a_q;
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic sda_a_q, sda_s_q, sda_p_q;
   logic scl_a_q, scl_s_q, scl_p_q;

   // Inputs sampled in every mode; previous copy for edges
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         sda_a_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
         scl_a_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
      end else begin
         sda_a_q <= data_input_pin_in;
         sda_s_q <= sda_a_q;
         sda_p_q <= sda_s_q;
         scl_a_q <= serial_clock_pin_in;
         scl_s_q <= scl_a_q;
         scl_p_q <= scl_s_q;
      end
   end

   // ----------------------------------------
   // Decode and events
   // ----------------------------------------
   logic sie_q, oie_q, clk_sel_q;
   uwc_pkg::uwc_wm_t wm_q;
   uwc_pkg::uwc_cs_t cs_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic sif_q, oif_q, pf_q;
   logic two_wire, wr_ctrl, wr_stat, wr_data;
   logic scl_pos, scl_neg, scl_any;
   logic start_det, stop_det;
   logic sw_tick, tc_tick, cnt_tick, sh_tick, wrap;
   logic [1:0] w_cs;

   assign two_wire = wm_q[1];
   assign wr_ctrl = wr_in && (addr_in == uwc_pkg::CTRL_OFS);
   assign wr_stat = wr_in && (addr_in == uwc_pkg::STAT_OFS);
   assign wr_data = wr_in && (addr_in == uwc_pkg::DATA_OFS);
   assign w_cs = wdata_in[uwc_pkg::C_CS_HI:uwc_pkg::C_CS_LO];

   // Edges on synchronised clock; both count when external
   assign scl_pos = scl_s_q && !scl_p_q;
   assign scl_neg = !scl_s_q && scl_p_q;
   assign scl_any = scl_pos || scl_neg;

   // Start/stop seen on the data line while clock stays high
   assign start_det = two_wire && scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
   assign stop_det = two_wire && scl_s_q && scl_p_q && sda_s_q && !sda_p_q;

   // Strobes act with the source written beside them
   assign sw_tick = wr_ctrl && wdata_in[uwc_pkg::C_CLK] && (w_cs == 2'h0);
   assign tc_tick = wr_ctrl && wdata_in[uwc_pkg::C_TC] && w_cs[1]
                    && wdata_in[uwc_pkg::C_CLK];

   // Counter clock select
   always_comb begin
      cnt_tick = sw_tick || tc_tick;
      if (cs_q == uwc_pkg::CS_TIMER) begin
         cnt_tick = cnt_tick || timer_match_in;
      end else if (cs_q[1] && !clk_sel_q) begin
         cnt_tick = cnt_tick || scl_any;
      end
   end

   // Shift clock select: one edge only when external
   always_comb begin
      unique case (cs_q)
         uwc_pkg::CS_SOFT: sh_tick = sw_tick;
         uwc_pkg::CS_TIMER: sh_tick = timer_match_in;
         uwc_pkg::CS_EXT_POS: sh_tick = scl_pos;
         uwc_pkg::CS_EXT_NEG: sh_tick = scl_neg;
      endcase
   end

   assign wrap = cnt_tick && (cnt_q == uwc_pkg::CNT_MAX) && !wr_stat;

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   // Clock-select copy keeps the write value but reads as zero
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         sie_q <= 1'b0;
         oie_q <= 1'b0;
         wm_q <= uwc_pkg::WM_OFF;
         cs_q <= uwc_pkg::CS_SOFT;
         clk_sel_q <= 1'b0;
      end else if (wr_ctrl) begin
         sie_q <= wdata_in[uwc_pkg::C_SIE];
         oie_q <= wdata_in[uwc_pkg::C_OIE];
         wm_q <= uwc_pkg::uwc_wm_t'(wdata_in[uwc_pkg::C_WM_HI:uwc_pkg::C_WM_LO]);
         cs_q <= uwc_pkg::uwc_cs_t'(w_cs);
         clk_sel_q <= wdata_in[uwc_pkg::C_CLK];
      end
   end

   // ----------------------------------------
   // Counter and shift register
   // ----------------------------------------
   // Software write beats a tick in the same cycle
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= uwc_pkg::CNT_RST;
      end else if (wr_stat) begin
         cnt_q <= wdata_in[uwc_pkg::S_CNT_HI:0];
      end else if (cnt_tick) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // Left shift, data pin into bit 0; write wins over shift
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= uwc_pkg::DATA_RST;
      end else if (wr_data) begin
         sh_q <= wdata_in;
      end else if (sh_tick) begin
         sh_q <= {sh_q[6:0], sda_s_q};
      end
   end

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   // A set in the clearing cycle wins, so no event is lost
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         sif_q <= 1'b0;
         oif_q <= 1'b0;
         pf_q <= 1'b0;
      end else begin
         if (two_wire ? start_det : cnt_tick) begin
            sif_q <= 1'b1;
         end else if (wr_stat && wdata_in[uwc_pkg::S_SIF]) begin
            sif_q <= 1'b0;
         end
         if (wrap) begin
            oif_q <= 1'b1;
         end else if (wr_stat && wdata_in[uwc_pkg::S_OIF]) begin
            oif_q <= 1'b0;
         end
         if (stop_det) begin
            pf_q <= 1'b1;
         end else if (wr_stat && wdata_in[uwc_pkg::S_PF]) begin
            pf_q <= 1'b0;
         end
      end
   end

   // Stop flag feeds no request; only start and overflow do
   assign start_irq_out = sif_q && sie_q;
   assign ovf_irq_out = oif_q && oie_q;

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   logic [7:0] stat_v;

   assign stat_v = {sif_q, oif_q, pf_q, sh_q[7] != sda_s_q, cnt_q};

   // Data one cycle after the strobe; strobe bits read zero
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         unique case (addr_in)
            uwc_pkg::CTRL_OFS: rdata_out <= {sie_q, oie_q, wm_q, cs_q, 2'h0};
            uwc_pkg::STAT_OFS: rdata_out <= stat_v;
            uwc_pkg::DATA_OFS: rdata_out <= sh_q;
            default: rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // ----------------------------------------
   // Pin steering
   // ----------------------------------------
   logic hold_start, hold_ovf;

   // Holds need the clock driver enabled by its direction bit
   assign hold_start = two_wire && sif_q;
   assign hold_ovf = (wm_q == uwc_pkg::WM_TWO_HOLD) && oif_q;

   // Three-wire overrides the port bit only; mode zero is plain port
   assign do_out = (wm_q == uwc_pkg::WM_THREE) ? sh_q[7] : port_do_in;
   assign do_oe_out = ddr_do_in;
   assign do_pullup_out = !ddr_do_in && port_do_in;

   // Open drain: only ever drives low in two-wire
   assign sda_out = two_wire ? 1'b0 : port_sda_in;
   assign sda_oe_out = ddr_sda_in && (!two_wire || !sh_q[7] || !port_sda_in);
   assign scl_out = two_wire ? 1'b0 : port_scl_in;
   assign scl_oe_out = ddr_scl_in
                       && (!two_wire || !port_scl_in || hold_start || hold_ovf);
   assign sda_pullup_out = !two_wire && !ddr_sda_in && port_sda_in;
   assign scl_pullup_out = !two_wire && !ddr_scl_in && port_scl_in;

   // Toggle strobe flips the clock port bit held outside
   assign scl_toggle_out = wr_ctrl && wdata_in[uwc_pkg::C_TC];

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n);

   sequence s_stop_seen;
      stop_det;
   endsequence

   a_stop_sets_flag: assert property (s_stop_seen |=> pf_q)
      else $error("stop flag not set");
   a_collision_bit: assert property (rd_in && addr_in == uwc_pkg::STAT_OFS |=>
                                     rdata_out[4] == ($past(sh_q[7]) != $past(sda_s_q)))
      else $error("collision bit wrong");
   a_cnt_write: assert property (wr_stat |=> cnt_q == $past(wdata_in[3:0]))
      else $error("counter write lost");
   a_cnt_step: assert property (cnt_tick && !wr_stat |=> cnt_q == $past(cnt_q) + 4'h1)
      else $error("counter did not step");
   a_cnt_still: assert property (!cnt_tick && !wr_stat |=> $stable(cnt_q))
      else $error("counter moved without clock");
   a_tc_ticks: assert property (tc_tick && !wr_stat |=> cnt_q != $past(cnt_q))
      else $error("toggle strobe ignored");
   a_ovf_wrap: assert property (wrap |=> oif_q && cnt_q == 4'h0)
      else $error("wrap missed");
   a_irq_gate: assert property (start_irq_out == (sif_q && sie_q)
                                && ovf_irq_out == (oif_q && oie_q))
      else $error("request not gated");
   a_start_hold: assert property (two_wire && sif_q && ddr_scl_in |->
                                  scl_oe_out && !scl_out)
      else $error("clock not held");
   a_tw_pullups: assert property (two_wire |-> !sda_pullup_out && !scl_pullup_out)
      else $error("pull-up on in two-wire");
   a_strobe_rd0: assert property (rd_in && addr_in == uwc_pkg::CTRL_OFS
                                  |=> rdata_out[1:0] == 2'h0)
      else $error("strobe bits read back");
endmodule

// ===== uwc_bus_dev.sv
// Model of an external master on the two serial lines.
// Assumes the bench pulls each line up and ANDs in every pull-low.
`timescale 1ns/10ps
module uwc_bus_dev (
   // Clock line level seen on the bus
   input wire logic scl_line_in,
   // Pull-low drives; a released line floats to its pull-up
   output logic sda_low_out,
   output logic scl_low_out
);
   localparam realtime half_ns = 62.5;
   // Lines released outside frames, so the clock stands still
   initial begin
      sda_low_out = 1'b0;
      scl_low_out = 1'b0;
   end
   // Start: data falls while clock high, then clock falls
   task automatic start_c();
      sda_low_out = 1'b1;
      #half_ns;
      scl_low_out = 1'b1;
      #half_ns;
   endtask
   // Stop: clock first; a held clock stretches the wait
   task automatic stop_c();
      sda_low_out = 1'b1;
      scl_low_out = 1'b0;
      wait (scl_line_in);
      #half_ns;
      sda_low_out = 1'b0;
      #half_ns;
   endtask
   // Master clock pulses, two edges each
   task automatic pulse(input int n);
      repeat (n) begin
         scl_low_out = 1'b1;
         #half_ns;
         scl_low_out = 1'b0;
         #half_ns;
      end
   endtask
endmodule

// ===== uwc_top_test.sv
// Self-checking bench for the serial wire control block.
// Assumes uwc_bus_dev plays the master on the shared open-drain lines.
`timescale 1ns/10ps
module uwc_top_test;
   logic clk_sys_in, rst_n_in, wr_in, rd_in, timer_match_in;
   logic [7:0] addr_in, wdata_in, rdata_out, v;
   logic port_do_in, ddr_do_in, port_sda_in, ddr_sda_in, port_scl_in, ddr_scl_in;
   logic do_out, do_oe_out, do_pullup_out, sda_out, sda_oe_out, sda_pullup_out;
   logic scl_out, scl_oe_out, scl_pullup_out, start_irq_out, ovf_irq_out, scl_toggle_out;
   logic sda_low, scl_low, sda_line, scl_line;
   logic [31:0] lfsr_q;
   int err_total, checks_done, cyc, n;
   // Pull-ups on both lines: any party pulling low wins
   assign sda_line = !((sda_oe_out && !sda_out) || sda_low);
   assign scl_line = !((scl_oe_out && !scl_out) || scl_low);
   uwc_top i_uwc_top (.clk_sys_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .port_do_in, .ddr_do_in, .port_sda_in, .ddr_sda_in, .port_scl_in,
      .ddr_scl_in, .timer_match_in, .data_input_pin_in(sda_line),
      .serial_clock_pin_in(scl_line), .do_out, .do_oe_out, .do_pullup_out, .sda_out,
      .sda_oe_out, .sda_pullup_out, .scl_out, .scl_oe_out, .scl_pullup_out,
      .scl_toggle_out, .start_irq_out, .ovf_irq_out);
   uwc_bus_dev i_uwc_bus_dev (.scl_line_in(scl_line), .sda_low_out(sda_low),
      .scl_low_out(scl_low));
   // 125 MHz system clock
   initial begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   // -----------------------------
   // Helpers
   // -----------------------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Status after k loaded and m ticks outside two-wire mode
   function automatic logic [7:0] exp_stat(input int k, input int m);
      return {1'b1, k + m > 15, 2'b00, 4'((k + m) % 16)};
   endfunction
   // One bus cycle; every signal assigned once per edge
   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      wr_in <= w;
      rd_in <= r;
      addr_in <= a;
      wdata_in <= d;
   endtask
   task automatic nop(input int k);
      repeat (k) op(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      op(1'b1, 1'b0, a, d);
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      op(1'b0, 1'b1, a, 8'h00);
      nop(1);
      #1;
      chk(nm, e, rdata_out);
   endtask
   task automatic pin(input string nm, input logic e, input logic g);
      chk(nm, {7'h00, e}, {7'h00, g});
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Hang guard, far above the few hundred cycles needed
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         close_out();
      end
   end
   // Main sequence
   initial begin
      {wr_in, rd_in, timer_match_in, addr_in, wdata_in} = '0;
      {port_do_in, ddr_do_in, port_sda_in, ddr_sda_in, port_scl_in, ddr_scl_in} = '0;
      rst_n_in = 1'b0;
      lfsr_q = 32'h92D3;
      repeat (12) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      nop(2);
      rd(uwc_pkg::CTRL_OFS, uwc_pkg::CTRL_RST, "ctrl");
      // Idle-high data line differs from the cleared shift MSB, so collision reads one
      rd(uwc_pkg::STAT_OFS, uwc_pkg::STAT_RST | 8'h10, "stat");
      wr(uwc_pkg::CTRL_OFS, 8'hCD);
      #1;
      pin("toggle", 1'b1, scl_toggle_out);
      rd(uwc_pkg::CTRL_OFS, 8'hCC, "ctrl");
      rd(uwc_pkg::STAT_OFS, 8'h10, "tc_alone");
      wr(uwc_pkg::CTRL_OFS, 8'hCF);
      rd(uwc_pkg::STAT_OFS, 8'h91, "tc_ext");
      pin("start_irq", 1'b1, start_irq_out);
      rd(8'h00, 8'h00, "unmapped");
      $display("test registers done");
      // Shift register full of ones so the idle-high data pin never collides in the counter tests
      wr(uwc_pkg::DATA_OFS, 8'hFF);
      for (int r = 0; r < 3; r++) begin
         lfsr_q = nxt(lfsr_q);
         v = {4'h0, lfsr_q[3:0]};
         n = 1 + int'(lfsr_q[8:4]);
         wr(uwc_pkg::STAT_OFS, 8'hE0 | v);
         wr(uwc_pkg::CTRL_OFS, 8'h40);
         repeat (n) wr(uwc_pkg::CTRL_OFS, 8'h42);
         nop(1);
         rd(uwc_pkg::STAT_OFS, exp_stat(v, n), "soft_count");
         pin("ovf_irq", v + n > 15, ovf_irq_out);
      end
      $display("test strobe done");
      wr(uwc_pkg::STAT_OFS, 8'hE0);
      wr(uwc_pkg::CTRL_OFS, 8'h04);
      nop(1);
      n = 1 + int'(lfsr_q[11:9]);
      repeat (n) begin
         @(posedge clk_sys_in);
         timer_match_in <= 1'b1;
         @(posedge clk_sys_in);
         timer_match_in <= 1'b0;
      end
      nop(2);
      rd(uwc_pkg::STAT_OFS, exp_stat(0, n), "timer");
      wr(uwc_pkg::STAT_OFS, 8'hE0);
      wr(uwc_pkg::CTRL_OFS, 8'h08);
      nop(1);
      n = 1 + int'(lfsr_q[13:12]);
      i_uwc_bus_dev.pulse(n);
      nop(6);
      rd(uwc_pkg::STAT_OFS, exp_stat(0, 2 * n), "ext_off");
      $display("test counter sources done");
      wr(uwc_pkg::STAT_OFS, 8'hE0);
      {port_sda_in, ddr_sda_in, port_scl_in, ddr_scl_in} <= 4'hF;
      wr(uwc_pkg::CTRL_OFS, 8'hE0);
      nop(2);
      pin("sda_pullup", 1'b0, sda_pullup_out);
      pin("scl_pullup", 1'b0, scl_pullup_out);
      pin("sda_free", 1'b0, sda_oe_out);
      i_uwc_bus_dev.start_c();
      nop(6);
      pin("start_hold", 1'b1, scl_oe_out);
      rd(uwc_pkg::STAT_OFS, 8'h90, "start");
      wr(uwc_pkg::STAT_OFS, 8'h80);
      nop(2);
      pin("start_hold", 1'b0, scl_oe_out);
      i_uwc_bus_dev.stop_c();
      nop(6);
      rd(uwc_pkg::STAT_OFS, 8'h20, "stop");
      pin("stop_irq", 1'b0, start_irq_out);
      // Ports low one line at a time so no start or stop is formed
      port_scl_in <= 1'b0;
      nop(4);
      pin("scl_port", 1'b1, scl_oe_out);
      port_sda_in <= 1'b0;
      nop(4);
      pin("sda_port", 1'b1, sda_oe_out);
      port_sda_in <= 1'b1;
      nop(4);
      port_scl_in <= 1'b1;
      nop(4);
      wr(uwc_pkg::CTRL_OFS, 8'h30);
      wr(uwc_pkg::STAT_OFS, 8'h2F);
      wr(uwc_pkg::CTRL_OFS, 8'h32);
      nop(3);
      pin("ovf_hold", 1'b1, scl_oe_out);
      rd(uwc_pkg::STAT_OFS, 8'h40, "wrap");
      wr(uwc_pkg::STAT_OFS, 8'h40);
      nop(2);
      pin("ovf_hold", 1'b0, scl_oe_out);
      $display("test two-wire done");
      wr(uwc_pkg::CTRL_OFS, 8'h10);
      ddr_do_in <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         wr(uwc_pkg::DATA_OFS, {i[0], 7'h00});
         nop(2);
         pin("do_msb", i[0], do_out);
      end
      ddr_do_in <= 1'b0;
      port_do_in <= 1'b1;
      nop(2);
      pin("do_pullup", 1'b1, do_pullup_out);
      wr(uwc_pkg::CTRL_OFS, 8'h00);
      ddr_do_in <= 1'b1;
      port_do_in <= lfsr_q[0];
      nop(2);
      pin("do_port", lfsr_q[0], do_out);
      pin("do_oe", 1'b1, do_oe_out);
      $display("test pins done");
      close_out();
   end
endmodule
